// >>> src/acu_unary_alu.sv
`timescale 1ns/100ps
// Function
// - Decode decrement: 00rrr101 register, 35 pointer pair, DD/FD 35 d indexed.
// - Register field 000..101 picks B..L, 111 accumulator, 110 is memory.
// - Decrement writes back byte minus one in 4, 11 or 23 states.
// - Decrement sets S, Z, H on borrow from bit 4, PV on 80h, N; C kept.
// - Adjust after addition adds 00, 06, 60 or 66 per nibbles and flags.
// - Adjust after subtraction adds 00, FA, A0 or 9A per nibbles and flags.
// - Adjust sets carry when upper correction applied, else clears; H per table.
// - Adjust sets S, Z, even parity on PV; N unchanged.
// - Opcode 2F inverts accumulator in 4 states, sets H and N only.
// - ED 44 replaces accumulator by zero minus it in 8 states.
// - Negating 80h leaves 80h.
// - Negation sets S, Z, H on borrow from bit 4, PV on 80h, N.
// - Negation sets carry when accumulator was non-zero, else clears it.
// - Opcode 3F inverts carry in 4 states, clears N, keeps S, Z, PV.
// - Carry invert copies old carry into H.
// - Carry force sets C, clears H and N in 4 states.
module acu_unary_alu (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta_q, rstSync_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {rstSync_q, rstMeta_q} <= 2'b00;
    end else begin
      {rstSync_q, rstMeta_q} <= {rstMeta_q, 1'b1};
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstSync_q);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic [9:0] decodeFn(input logic [7:0] b0,
                                          input logic [7:0] b1);
    logic [9:0] d;
    d = 10'h000;
    if ((b0 == acu_pkg::OPC_PFX_X || b0 == acu_pkg::OPC_PFX_Y)
        && b1 == acu_pkg::OPC_DECR_MEM) begin
      d = {1'b1, 1'b1, acu_pkg::ACU_DECM, acu_pkg::T_IDX};
    end else if (b0 == acu_pkg::OPC_PFX_ED && b1 == acu_pkg::OPC_NEGATE) begin
      d = {1'b1, 1'b0, acu_pkg::ACU_NEGATE, acu_pkg::T_NEGATE};
    end else if (b0[7:6] == acu_pkg::DECR_HI
                 && b0[2:0] == acu_pkg::DECR_LO) begin
      if (b0[5:3] == acu_pkg::SEL_MEM) begin
        d = {1'b1, 1'b0, acu_pkg::ACU_DECM, acu_pkg::T_PTR};
      end else begin
        d = {1'b1, 1'b0, acu_pkg::ACU_DECR, acu_pkg::T_REG};
      end
    end else if (b0 == acu_pkg::OPC_BCD_ADJ) begin
      d = {1'b1, 1'b0, acu_pkg::ACU_BCDADJ, acu_pkg::T_REG};
    end else if (b0 == acu_pkg::OPC_INVERT) begin
      d = {1'b1, 1'b0, acu_pkg::ACU_INVERT, acu_pkg::T_REG};
    end else if (b0 == acu_pkg::OPC_CY_INV) begin
      d = {1'b1, 1'b0, acu_pkg::ACU_CYINV, acu_pkg::T_REG};
    end else if (b0 == acu_pkg::OPC_CY_SET) begin
      d = {1'b1, 1'b0, acu_pkg::ACU_CYSET, acu_pkg::T_REG};
    end
    return d;
  endfunction : decodeFn

  function automatic logic [15:0] bcdAdjFn(input logic [7:0] a,
                                           input logic [7:0] f);
    logic lowAdj, highAdj;
    logic [7:0] corr, r, nf;
    lowAdj = f[acu_pkg::FL_H] | (a[3:0] > acu_pkg::DIG_MAX);
    highAdj = f[acu_pkg::FL_C] | (a > acu_pkg::BCD_MAX);
    nf = f;
    if (!f[acu_pkg::FL_N]) begin
      unique case ({highAdj, lowAdj})
        2'b00: corr = acu_pkg::ADD_00;
        2'b01: corr = acu_pkg::ADD_06;
        2'b10: corr = acu_pkg::ADD_60;
        2'b11: corr = acu_pkg::ADD_66;
      endcase
      nf[acu_pkg::FL_H] = a[3:0] > acu_pkg::DIG_MAX;
    end else begin
      unique case ({highAdj, lowAdj})
        2'b00: corr = acu_pkg::ADD_00;
        2'b01: corr = acu_pkg::SUB_06;
        2'b10: corr = acu_pkg::SUB_60;
        2'b11: corr = acu_pkg::SUB_66;
      endcase
      nf[acu_pkg::FL_H] = f[acu_pkg::FL_H] & (a[3:0] < acu_pkg::DIG_SUB);
    end
    r = a + corr;
    nf[acu_pkg::FL_C] = highAdj;
    nf[acu_pkg::FL_S] = r[7];
    nf[acu_pkg::FL_Z] = (r == 8'h00);
    nf[acu_pkg::FL_PV] = ~^r;
    return {r, nf};
  endfunction : bcdAdjFn

  // ****************************************
  // Bus request
  // ****************************************
  acu_pkg::acu_state_t state_q;
  acu_pkg::acu_op_t op_q;
  logic [7:0] regFile_q [0:7];
  logic [7:0] mem_q, accQ, flagQ;
  logic [15:0] idxX_q, idxY_q, ea_q, eaD;
  logic [4:0] tCnt_q;
  logic [2:0] tgt_q;
  logic [31:0] wbDat_q;
  logic [9:0] opDec;
  logic ill_q, wbAck_q, reqNew, wrIdle, cmdWr, launch, commit;
  assign accQ = regFile_q[acu_pkg::SEL_ACC];
  assign flagQ = regFile_q[acu_pkg::SEL_MEM];
  assign reqNew = wb_cyc_i & wb_stb_i & ~wbAck_q;
  assign wrIdle = reqNew & wb_we_i & wb_sel_i[0]
    & (state_q == acu_pkg::ACU_IDLE);
  assign cmdWr = wrIdle & (wb_adr_i == acu_pkg::OFF_CMD);
  assign opDec = decodeFn(wb_dat_i[7:0], wb_dat_i[15:8]);
  assign launch = cmdWr & opDec[9];
  assign commit = (state_q == acu_pkg::ACU_EXEC) & (tCnt_q == 5'h00);
  assign eaD = opDec[8] ? (idxX_q + {{8{wb_dat_i[23]}}, wb_dat_i[23:16]})
    : {regFile_q[4], regFile_q[5]};

  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= acu_pkg::ACU_IDLE;
      tCnt_q <= 5'h00;
      op_q <= acu_pkg::ACU_DECR;
      tgt_q <= 3'h0;
    end else if (launch) begin
      state_q <= acu_pkg::ACU_EXEC;
      tCnt_q <= opDec[4:0] - 5'h01;
      op_q <= acu_pkg::acu_op_t'(opDec[7:5]);
      tgt_q <= wb_dat_i[5:3];
    end else if (commit) begin
      state_q <= acu_pkg::ACU_IDLE;
    end else if (state_q == acu_pkg::ACU_EXEC) begin
      tCnt_q <= tCnt_q - 5'h01;
    end
  end
  assign busy = state_q;

  // ****************************************
  // Result
  // ****************************************
  logic [7:0] opnd, res, newF;
  logic [15:0] bcdAdj;
  always_comb begin
    opnd = (op_q == acu_pkg::ACU_DECM) ? mem_q : regFile_q[tgt_q];
    bcdAdj = bcdAdjFn(accQ, flagQ);
    res = accQ;
    newF = flagQ;
    unique case (op_q)
      acu_pkg::ACU_DECR, acu_pkg::ACU_DECM: begin
        res = opnd - 8'h01;
        newF[acu_pkg::FL_S] = res[7];
        newF[acu_pkg::FL_Z] = (res == 8'h00);
        newF[acu_pkg::FL_H] = (opnd[3:0] == 4'h0);
        newF[acu_pkg::FL_PV] = (opnd == acu_pkg::BYTE_MIN);
        newF[acu_pkg::FL_N] = 1'b1;
      end
      acu_pkg::ACU_BCDADJ: begin
        res = bcdAdj[15:8];
        newF = bcdAdj[7:0];
      end
      acu_pkg::ACU_INVERT: begin
        res = ~accQ;
        newF[acu_pkg::FL_H] = 1'b1;
        newF[acu_pkg::FL_N] = 1'b1;
      end
      acu_pkg::ACU_NEGATE: begin
        res = 8'h00 - accQ;
        newF[acu_pkg::FL_S] = res[7];
        newF[acu_pkg::FL_Z] = (res == 8'h00);
        newF[acu_pkg::FL_H] = (accQ[3:0] != 4'h0);
        newF[acu_pkg::FL_PV] = (accQ == acu_pkg::BYTE_MIN);
        newF[acu_pkg::FL_N] = 1'b1;
        newF[acu_pkg::FL_C] = (accQ != 8'h00);
      end
      acu_pkg::ACU_CYINV: begin
        newF[acu_pkg::FL_H] = flagQ[acu_pkg::FL_C];
        newF[acu_pkg::FL_N] = 1'b0;
        newF[acu_pkg::FL_C] = ~flagQ[acu_pkg::FL_C];
      end
      acu_pkg::ACU_CYSET: begin
        newF[acu_pkg::FL_H] = 1'b0;
        newF[acu_pkg::FL_N] = 1'b0;
        newF[acu_pkg::FL_C] = 1'b1;
      end
      default: begin
        res = accQ;
      end
    endcase
  end

  // ****************************************
  // Architectural state
  // ****************************************
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      for (int i = 0; i < 8; i++) begin
        regFile_q[i] <= acu_pkg::RST_BYTE;
      end
      mem_q <= acu_pkg::RST_BYTE;
    end else if (commit) begin
      regFile_q[acu_pkg::SEL_MEM] <= newF;
      if (op_q == acu_pkg::ACU_DECM) begin
        mem_q <= res;
      end else if (op_q == acu_pkg::ACU_DECR) begin
        regFile_q[tgt_q] <= res;
      end else begin
        regFile_q[acu_pkg::SEL_ACC] <= res;
      end
    end else if (wrIdle && wb_adr_i[7:5] == 3'h0 && ~|wb_adr_i[1:0]) begin
      regFile_q[wb_adr_i[4:2]] <= wb_dat_i[7:0];
    end else if (wrIdle && wb_adr_i == acu_pkg::OFF_MEM) begin
      mem_q <= wb_dat_i[7:0];
    end
  end
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      idxX_q <= acu_pkg::RST_WORD;
      idxY_q <= acu_pkg::RST_WORD;
    end else if (wrIdle && wb_sel_i[1]) begin
      if (wb_adr_i == acu_pkg::OFF_IDXX) idxX_q <= wb_dat_i[15:0];
      if (wb_adr_i == acu_pkg::OFF_IDXY) idxY_q <= wb_dat_i[15:0];
    end
  end
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ea_q <= acu_pkg::RST_WORD;
    end else if (launch && opDec[7:5] == acu_pkg::ACU_DECM) begin
      ea_q <= (wb_dat_i[7:0] == acu_pkg::OPC_PFX_Y)
        ? idxY_q + {{8{wb_dat_i[23]}}, wb_dat_i[23:16]} : eaD;
    end
  end
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ill_q <= 1'b0;
    end else if (cmdWr && !opDec[9]) begin
      ill_q <= 1'b1;
    end else if (wrIdle && wb_adr_i == acu_pkg::OFF_STAT
                 && wb_dat_i[acu_pkg::ST_ILL]) begin
      ill_q <= 1'b0;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge mclk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end else begin
      wbAck_q <= reqNew;
      if (reqNew && !wb_we_i) begin
        wbDat_q <= 32'h0000_0000;
        if (wb_adr_i[7:5] == 3'h0 && wb_adr_i[1:0] == 2'h0) begin
          wbDat_q[7:0] <= regFile_q[wb_adr_i[4:2]];
        end else if (wb_adr_i == acu_pkg::OFF_MEM) begin
          wbDat_q[7:0] <= mem_q;
        end else if (wb_adr_i == acu_pkg::OFF_IDXX) begin
          wbDat_q[15:0] <= idxX_q;
        end else if (wb_adr_i == acu_pkg::OFF_IDXY) begin
          wbDat_q[15:0] <= idxY_q;
        end else if (wb_adr_i == acu_pkg::OFF_STAT) begin
          wbDat_q[acu_pkg::ST_BUSY] <= state_q;
          wbDat_q[acu_pkg::ST_ILL] <= ill_q;
          wbDat_q[acu_pkg::ST_TCNT +: 5] <= tCnt_q;
        end else if (wb_adr_i == acu_pkg::OFF_EA) begin
          wbDat_q[15:0] <= ea_q;
        end
      end
    end
  end
  assign wb_ack_o = wbAck_q;
  assign wb_dat_o = wbDat_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_decr_time;
    launch && opDec[7:5] == acu_pkg::ACU_DECR |=> busy [*4] ##1 !busy;
  endproperty
  a_decr_time: assert property (p_decr_time) else $error("reg time");
  property p_idx_time;
    launch && opDec[8] |=> busy ##22 busy ##1 !busy;
  endproperty
  a_idx_time: assert property (p_idx_time) else $error("idx time");
  property p_decr_flags;
    commit && op_q == acu_pkg::ACU_DECM |=> mem_q == $past(mem_q) - 8'h01
      && flagQ[acu_pkg::FL_N] && flagQ[acu_pkg::FL_C] == $past(flagQ[0])
      && flagQ[acu_pkg::FL_PV] == ($past(mem_q) == 8'h80);
  endproperty
  a_decr_flags: assert property (p_decr_flags) else $error("dflags");
  property p_decr_sel;
    commit && op_q == acu_pkg::ACU_DECR |-> tgt_q != acu_pkg::SEL_MEM;
  endproperty
  a_decr_sel: assert property (p_decr_sel) else $error("bad reg sel");
  property p_negate;
    commit && op_q == acu_pkg::ACU_NEGATE |=> accQ == 8'h00 - $past(accQ)
      && flagQ[acu_pkg::FL_C] == ($past(accQ) != 8'h00);
  endproperty
  a_negate: assert property (p_negate) else $error("negate result");
  property p_invert;
    commit && op_q == acu_pkg::ACU_INVERT |=> accQ == ~$past(accQ)
      && flagQ[acu_pkg::FL_H] && flagQ[acu_pkg::FL_N];
  endproperty
  a_invert: assert property (p_invert) else $error("invert result");
  property p_cy_inv;
    commit && op_q == acu_pkg::ACU_CYINV |=> flagQ[0] == !$past(flagQ[0])
      && flagQ[acu_pkg::FL_H] == $past(flagQ[0]) && !flagQ[acu_pkg::FL_N];
  endproperty
  a_cy_inv: assert property (p_cy_inv) else $error("carry invert");
  property p_cy_set;
    commit && op_q == acu_pkg::ACU_CYSET |=> flagQ[0]
      && !flagQ[acu_pkg::FL_H] && !flagQ[acu_pkg::FL_N];
  endproperty
  a_cy_set: assert property (p_cy_set) else $error("carry force");
  property p_adj_carry;
    commit && op_q == acu_pkg::ACU_BCDADJ |=> flagQ[0] ==
      ($past(flagQ[0]) || $past(accQ) > 8'h99);
  endproperty
  a_adj_carry: assert property (p_adj_carry) else $error("adj carry");
endmodule : acu_unary_alu

// >>> src/acu_pkg.sv
// ****************************************
// Constants
// ****************************************
package acu_pkg;
  localparam logic [7:0] OPC_DECR_MEM = 8'h35;
  localparam logic [7:0] OPC_PFX_X = 8'hdd;
  localparam logic [7:0] OPC_PFX_Y = 8'hfd;
  localparam logic [7:0] OPC_PFX_ED = 8'hed;
  localparam logic [7:0] OPC_NEGATE = 8'h44;
  localparam logic [7:0] OPC_BCD_ADJ = 8'h27;
  localparam logic [7:0] OPC_INVERT = 8'h2f;
  localparam logic [7:0] OPC_CY_INV = 8'h3f;
  localparam logic [7:0] OPC_CY_SET = 8'h37;
  localparam logic [1:0] DECR_HI = 2'h0;
  localparam logic [2:0] DECR_LO = 3'h5;
  localparam logic [2:0] SEL_MEM = 3'h6;
  localparam logic [2:0] SEL_ACC = 3'h7;
  localparam logic [4:0] T_REG = 5'h04;
  localparam logic [4:0] T_PTR = 5'h0b;
  localparam logic [4:0] T_IDX = 5'h17;
  localparam logic [4:0] T_NEGATE = 5'h08;
  localparam int FL_S = 7;
  localparam int FL_Z = 6;
  localparam int FL_H = 4;
  localparam int FL_PV = 2;
  localparam int FL_N = 1;
  localparam int FL_C = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_ILL = 1;
  localparam int ST_TCNT = 8;
  localparam logic [7:0] OFF_MEM = 8'h20;
  localparam logic [7:0] OFF_IDXX = 8'h24;
  localparam logic [7:0] OFF_IDXY = 8'h28;
  localparam logic [7:0] OFF_CMD = 8'h2c;
  localparam logic [7:0] OFF_STAT = 8'h30;
  localparam logic [7:0] OFF_EA = 8'h34;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] BYTE_MIN = 8'h80;
  localparam logic [7:0] BCD_MAX = 8'h99;
  localparam logic [3:0] DIG_MAX = 4'h9;
  localparam logic [3:0] DIG_SUB = 4'h6;
  localparam logic [7:0] ADD_00 = 8'h00;
  localparam logic [7:0] ADD_06 = 8'h06;
  localparam logic [7:0] ADD_60 = 8'h60;
  localparam logic [7:0] ADD_66 = 8'h66;
  localparam logic [7:0] SUB_06 = 8'hfa;
  localparam logic [7:0] SUB_60 = 8'ha0;
  localparam logic [7:0] SUB_66 = 8'h9a;
  typedef enum logic [2:0] {
    ACU_DECR = 3'h0, ACU_DECM = 3'h1, ACU_BCDADJ = 3'h2, ACU_INVERT = 3'h3,
    ACU_NEGATE = 3'h4, ACU_CYINV = 3'h5, ACU_CYSET = 3'h6
  } acu_op_t;
  typedef enum logic {ACU_IDLE = 1'b0, ACU_EXEC = 1'b1} acu_state_t;
endpackage : acu_pkg

// >>> tb/acu_unary_alu_test.sv
`timescale 1ns/100ps
module acu_unary_alu_test;
  logic mclk;
  logic rst_n;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic wbAck;
  logic busy;
  int fails;
  int totalChecks;
  logic [31:0] rd;

  acu_unary_alu acu_unary_alu_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .busy(busy)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat);
    int i;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (wbAck === 1'b1) break;
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (i == 50) begin
      fails++;
      give_verdict();
    end
  endtask : wb_cycle

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp,
                       input logic [31:0] mask);
    wb_cycle(1'b0, adr, 32'h00000000);
    check(rd & mask, exp);
  endtask : rdchk

  // Issue a command and count the cycles busy stays high
  task automatic run_cmd(input logic [23:0] cmd, input int n);
    int cnt;
    wb_cycle(1'b1, 8'h2c, {8'h00, cmd});
    cnt = 1;
    while (cnt < 60) begin
      @(posedge mclk);
      if (busy !== 1'b1) break;
      cnt++;
    end
    check(32'(cnt), 32'(n));
  endtask : run_cmd

  function automatic logic [31:0] fl(input logic [7:0] a, input logic h,
                                     input logic pv, input logic n,
                                     input logic c);
    return {24'h0, a[7], a == 8'h00, 1'b0, h, 1'b0, pv, n, c};
  endfunction : fl

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_dec_reg;
    logic [7:0] vals [8];
    logic [7:0] r;
    vals = '{8'h80, 8'h2a, 8'h01, 8'h10, 8'h00, 8'hff, 8'h00, 8'h55};
    for (int k = 0; k < 8; k++) begin
      if (k == 6) continue;
      wb_cycle(1'b1, 8'(k * 4), {24'h0, vals[k]});
      wb_cycle(1'b1, 8'h18, {31'h0, k[0]});
      run_cmd({16'h0000, 2'b00, 3'(k), 3'b101}, 4);
      r = vals[k] - 8'h01;
      rdchk(8'(k * 4), {24'h0, r}, 32'hff);
      rdchk(8'h18, fl(r, vals[k][3:0] == 4'h0, vals[k] == 8'h80, 1'b1,
            k[0]), 32'hd7);
    end
    $display("Test register decrement done");
  endtask : t_dec_reg

  task automatic t_dec_mem;
    wb_cycle(1'b1, 8'h10, 32'h12);
    wb_cycle(1'b1, 8'h14, 32'h34);
    wb_cycle(1'b1, 8'h20, 32'h01);
    wb_cycle(1'b1, 8'h18, 32'h00);
    run_cmd(24'h000035, 11);
    rdchk(8'h20, 32'h00, 32'hff);
    rdchk(8'h18, fl(8'h00, 1'b0, 1'b0, 1'b1, 1'b0), 32'hd7);
    rdchk(8'h34, 32'h1234, 32'hffff);
    wb_cycle(1'b1, 8'h24, 32'h2020);
    wb_cycle(1'b1, 8'h20, 32'h80);
    run_cmd(24'h1035dd, 23);
    rdchk(8'h34, 32'h2030, 32'hffff);
    rdchk(8'h20, 32'h7f, 32'hff);
    rdchk(8'h18, fl(8'h7f, 1'b1, 1'b1, 1'b1, 1'b0), 32'hd7);
    wb_cycle(1'b1, 8'h28, 32'h2020);
    run_cmd(24'hf035fd, 23);
    rdchk(8'h34, 32'h2010, 32'hffff);
    $display("Test memory decrement done");
  endtask : t_dec_mem

  task automatic t_adjust;
    logic [7:0] ai [8];
    logic [7:0] fi [8];
    logic [7:0] ax [8];
    logic [7:0] hc [8];
    ai = '{8'h3c, 8'h9a, 8'ha0, 8'h21, 8'h45, 8'h0f, 8'h70, 8'h66};
    fi = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h12, 8'h03, 8'h13};
    ax = '{8'h42, 8'h00, 8'h00, 8'h87, 8'h45, 8'h09, 8'h10, 8'h00};
    hc = '{8'h10, 8'h11, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01};
    for (int k = 0; k < 8; k++) begin
      wb_cycle(1'b1, 8'h1c, {24'h0, ai[k]});
      wb_cycle(1'b1, 8'h18, {24'h0, fi[k]});
      run_cmd(24'h000027, 4);
      rdchk(8'h1c, {24'h0, ax[k]}, 32'hff);
      rdchk(8'h18, fl(ax[k], hc[k][4], ~^ax[k], fi[k][1], hc[k][0]),
            32'hd7);
    end
    $display("Test decimal adjust done");
  endtask : t_adjust

  task automatic t_cpl_neg;
    logic [7:0] ni [3];
    logic [7:0] nx [3];
    wb_cycle(1'b1, 8'h1c, 32'hb4);
    wb_cycle(1'b1, 8'h18, 32'hc5);
    run_cmd(24'h00002f, 4);
    rdchk(8'h1c, 32'h4b, 32'hff);
    rdchk(8'h18, 32'hd7, 32'hd7);
    ni = '{8'h98, 8'h80, 8'h00};
    nx = '{8'h68, 8'h80, 8'h00};
    for (int k = 0; k < 3; k++) begin
      wb_cycle(1'b1, 8'h1c, {24'h0, ni[k]});
      wb_cycle(1'b1, 8'h18, 32'h00);
      run_cmd(24'h0044ed, 8);
      rdchk(8'h1c, {24'h0, nx[k]}, 32'hff);
      rdchk(8'h18, fl(nx[k], ni[k][3:0] != 4'h0, ni[k] == 8'h80, 1'b1,
            ni[k] != 8'h00), 32'hd7);
    end
    $display("Test complement and negate done");
  endtask : t_cpl_neg

  task automatic t_carry;
    wb_cycle(1'b1, 8'h18, 32'hc5);
    run_cmd(24'h00003f, 4);
    rdchk(8'h18, 32'hd4, 32'hd7);
    wb_cycle(1'b1, 8'h18, 32'h02);
    run_cmd(24'h00003f, 4);
    rdchk(8'h18, 32'h01, 32'hd7);
    wb_cycle(1'b1, 8'h18, 32'hd6);
    run_cmd(24'h000037, 4);
    rdchk(8'h18, 32'hc5, 32'hd7);
    $display("Test carry operations done");
  endtask : t_carry

  task automatic t_refuse;
    wb_cycle(1'b1, 8'h1c, 32'h33);
    wb_cycle(1'b1, 8'h2c, 32'h1035dd);
    wb_cycle(1'b1, 8'h1c, 32'h77);
    rdchk(8'h30, 32'h01, 32'h01);
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge mclk);
    if (busy !== 1'b0) begin
      fails++;
      give_verdict();
    end
    rdchk(8'h1c, 32'h33, 32'hff);
    run_cmd(24'h000076, 1);
    rdchk(8'h30, 32'h02, 32'h02);
    wb_cycle(1'b1, 8'h30, 32'h02);
    rdchk(8'h30, 32'h00, 32'h02);
    rdchk(8'h3c, 32'h00, 32'hffffffff);
    $display("Test refusals done");
  endtask : t_refuse

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fails = 0;
    totalChecks = 0;
    rst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatI = 32'h00000000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    rdchk(8'h1c, 32'h00, 32'hffffffff);
    rdchk(8'h18, 32'h00, 32'hffffffff);
    t_dec_reg();
    t_dec_mem();
    t_adjust();
    t_cpl_neg();
    t_carry();
    t_refuse();
    give_verdict();
  end
endmodule : acu_unary_alu_test
